// ==== art_timer_top.sv ====
// Auto-reload timer pair with slow-oscillator capture, SFR-style port
//
// Contract
// RQ1: The second timer's 16-bit count is two separately addressed bytes.
// RQ2: The second timer advances per 12 system clocks or 8 oscillator cycles.
// RQ3: A wrap from all ones loads the reload value and sets the timer flag.
// RQ4: With the timer interrupt enabled each 16-bit overflow requests one.
// RQ5: With interrupt and low-byte enable set, a low-byte wrap requests one.
// RQ6: The capture enable bit selects capture mode; clearing it leaves it.
// RQ7: In capture mode one capture event occurs per 8 oscillator cycles.
// RQ8: A capture copies the 16-bit count into the reload register pair.
// RQ9: A capture sets the timer flag and requests an interrupt if enabled.
// RQ10: Software measures period by differencing captures at a fast count.
// RQ11: The first timer's high count byte is read-write and resets to zero.
// RQ12: Clock select zero picks system clock / 12, one picks oscillator / 8.
// RQ13: The second timer counts only while its run bit, reset zero, is one.
// RQ14: The oscillator tick is synchronised into a one-cycle strobe.
// RQ15: The low-byte interrupt uses only the second timer's own enable; the code requires both the interrupt enable and the low-byte enable.
`timescale 1ns/10ps
module art_timer_top
    import art_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       slow_osc,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    output logic            irq_request
);

    function automatic logic all_ones8(input logic [7:0] v);
        return v == ART_BYTE_ONES;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return sfr_wr && (a == o);
    endfunction

    logic        rst_meta_reg;
    logic        rst_sync_n;
    logic [7:0]  t0_low_reg;
    logic [7:0]  t0_high_reg;
    logic [7:0]  ctrl_reg;
    logic [15:0] reload_reg;
    logic [15:0] count_reg;
    logic [7:0]  flag_reg;
    logic [7:0]  enable_reg;
    logic        tick;
    logic        step;
    logic        low_wrap;
    logic        overflow;
    logic        capture;
    logic [7:0]  rd_mux;

    art_tick_if ticks ();

    ////////////////////////////////////////////////////////////////////////
    // Reset release synchroniser
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    art_prescaler u_prescaler (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .slow_osc   (slow_osc),
        .ticks      (ticks.gen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event decode
    assign tick = ctrl_reg[ART_CTRL_CLK_SEL_BIT] ? ticks.osc8_tick
                                                 : ticks.sys12_tick; // RQ12
    assign step     = ctrl_reg[ART_CTRL_RUN_BIT] && tick; // RQ13
    assign low_wrap = step && all_ones8(count_reg[7:0]); // RQ5
    assign overflow = step && (count_reg == ART_WORD_ONES); // RQ3
    // Capture runs on the oscillator regardless of the run bit
    assign capture  = ctrl_reg[ART_CTRL_CAP_EN_BIT] && ticks.osc8_tick; // RQ6

    ////////////////////////////////////////////////////////////////////////
    // First timer count bytes, plain storage
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            t0_low_reg  <= ART_BYTE_RESET;
            t0_high_reg <= ART_BYTE_RESET; // RQ11
        end
        else
        begin
            if (hit(sfr_addr, ART_T0_COUNT_LOW_ADDR))
                t0_low_reg <= sfr_wdata;
            if (hit(sfr_addr, ART_T0_COUNT_HIGH_ADDR))
                t0_high_reg <= sfr_wdata; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Second timer control and enable
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_reg   <= ART_BYTE_RESET; // RQ13
            enable_reg <= ART_BYTE_RESET;
        end
        else
        begin
            if (hit(sfr_addr, ART_T1_CTRL_ADDR))
                ctrl_reg <= sfr_wdata & ART_CTRL_MASK; // RQ6
            if (hit(sfr_addr, ART_IRQ_ENABLE_ADDR))
                enable_reg <= sfr_wdata & ART_EN_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reload pair: capture beats a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reload_reg <= ART_WORD_RESET;
        else if (capture)
            reload_reg <= count_reg; // RQ8
        else
        begin
            if (hit(sfr_addr, ART_T1_RELOAD_LOW_ADDR))
                reload_reg[7:0] <= sfr_wdata;
            if (hit(sfr_addr, ART_T1_RELOAD_HIGH_ADDR))
                reload_reg[15:8] <= sfr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Count: a software byte write wins over the step in that cycle
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            count_reg <= ART_WORD_RESET;
        else if (hit(sfr_addr, ART_T1_COUNT_LOW_ADDR))
            count_reg[7:0] <= sfr_wdata; // RQ1
        else if (hit(sfr_addr, ART_T1_COUNT_HIGH_ADDR))
            count_reg[15:8] <= sfr_wdata; // RQ1
        else if (overflow)
            count_reg <= reload_reg; // RQ3
        else if (step)
            count_reg <= count_reg + 16'h0001; // RQ2
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: writing zero clears, a same-cycle event still sets
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            flag_reg <= ART_BYTE_RESET;
        else
        begin
            if (hit(sfr_addr, ART_IRQ_FLAG_ADDR))
                flag_reg <= flag_reg & sfr_wdata & ART_FLAG_MASK;
            if (overflow || capture)
                flag_reg[ART_FLAG_T1_BIT] <= 1'b1; // RQ3 RQ9
            if (low_wrap)
                flag_reg[ART_FLAG_T1_LOW_BIT] <= 1'b1; // RQ5
        end
    end

    // Request follows the flags one cycle later
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_request <= 1'b0;
        else
            irq_request <= enable_reg[ART_FLAG_T1_BIT]
                && (flag_reg[ART_FLAG_T1_BIT]                 // RQ4 RQ9
                    || (flag_reg[ART_FLAG_T1_LOW_BIT]
                        && ctrl_reg[ART_CTRL_LOW_IRQ_BIT])); // RQ5 RQ15
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port
    always_comb
    begin
        unique case (sfr_addr)
            ART_T0_COUNT_LOW_ADDR:   rd_mux = t0_low_reg;
            ART_T0_COUNT_HIGH_ADDR:  rd_mux = t0_high_reg;
            ART_T1_CTRL_ADDR:        rd_mux = ctrl_reg;
            ART_T1_RELOAD_LOW_ADDR:  rd_mux = reload_reg[7:0];
            ART_T1_RELOAD_HIGH_ADDR: rd_mux = reload_reg[15:8];
            ART_T1_COUNT_LOW_ADDR:   rd_mux = count_reg[7:0];
            ART_T1_COUNT_HIGH_ADDR:  rd_mux = count_reg[15:8];
            ART_IRQ_FLAG_ADDR:       rd_mux = flag_reg;
            ART_IRQ_ENABLE_ADDR:     rd_mux = enable_reg;
            default:                 rd_mux = ART_BYTE_RESET;
        endcase
    end

    // Bytes read separately; a carry between the two reads is not hidden
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sfr_rdata <= ART_BYTE_RESET;
        else if (sfr_rd)
            sfr_rdata <= rd_mux;
    end

endmodule

// ==== art_pkg.sv ====
// Constants for the auto-reload timer pair with oscillator capture
package art_pkg;

    // Register offsets
    localparam logic [7:0] ART_T0_COUNT_LOW_ADDR   = 8'h52;
    localparam logic [7:0] ART_T0_COUNT_HIGH_ADDR  = 8'h53;
    localparam logic [7:0] ART_T1_CTRL_ADDR        = 8'h54;
    localparam logic [7:0] ART_T1_RELOAD_LOW_ADDR  = 8'h55;
    localparam logic [7:0] ART_T1_RELOAD_HIGH_ADDR = 8'h56;
    localparam logic [7:0] ART_T1_COUNT_LOW_ADDR   = 8'h57;
    localparam logic [7:0] ART_T1_COUNT_HIGH_ADDR  = 8'h58;
    localparam logic [7:0] ART_IRQ_FLAG_ADDR       = 8'h59;
    localparam logic [7:0] ART_IRQ_ENABLE_ADDR     = 8'h5a;

    // Second timer control fields
    localparam int ART_CTRL_CLK_SEL_BIT   = 0;
    localparam int ART_CTRL_RUN_BIT       = 2;
    localparam int ART_CTRL_CAP_EN_BIT    = 4;
    localparam int ART_CTRL_LOW_IRQ_BIT   = 5;
    localparam logic [7:0] ART_CTRL_MASK  = 8'h35;

    // Interrupt flag and enable fields
    localparam int ART_FLAG_T1_BIT        = 3;
    localparam int ART_FLAG_T1_LOW_BIT    = 4;
    localparam logic [7:0] ART_FLAG_MASK  = 8'h18;
    localparam logic [7:0] ART_EN_MASK    = 8'h08;

    // Reset values
    localparam logic [7:0]  ART_BYTE_RESET  = 8'h00;
    localparam logic [15:0] ART_WORD_RESET  = 16'h0000;

    // Prescaler ratios
    localparam int ART_SYS_DIV = 12;
    localparam int ART_OSC_DIV = 8;
    localparam logic [3:0] ART_SYS_DIV_LAST = 4'(ART_SYS_DIV - 1);
    localparam logic [2:0] ART_OSC_DIV_LAST = 3'(ART_OSC_DIV - 1);

    localparam logic [7:0]  ART_BYTE_ONES = 8'hff;
    localparam logic [15:0] ART_WORD_ONES = 16'hffff;

endpackage

// ==== art_tick_if.sv ====
// Tick strobes passed from the prescaler to the timer core
`timescale 1ns/10ps
interface art_tick_if;
    logic sys12_tick;
    logic osc8_tick;

    modport gen (output sys12_tick, output osc8_tick);
    modport use_side (input sys12_tick, input osc8_tick);
endinterface

// ==== art_prescaler.sv ====
// Divide-by-12 system tick and synchronised divide-by-8 oscillator tick
`timescale 1ns/10ps
module art_prescaler
    import art_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    input  wire logic slow_osc,
    art_tick_if.gen   ticks
);

    logic [3:0] sys_cnt_reg;
    logic       osc_meta_reg;
    logic       osc_sync_reg;
    logic       osc_prev_reg;
    logic [2:0] osc_cnt_reg;
    logic       osc_rise;

    ////////////////////////////////////////////////////////////////////////
    // System clock divided by 12
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sys_cnt_reg      <= 4'h0;
            ticks.sys12_tick <= 1'b0;
        end
        else
        begin
            ticks.sys12_tick <= (sys_cnt_reg == ART_SYS_DIV_LAST); // RQ2
            if (sys_cnt_reg == ART_SYS_DIV_LAST)
                sys_cnt_reg <= 4'h0;
            else
                sys_cnt_reg <= sys_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator synchroniser; edge detect reads only the second and third stages
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_meta_reg <= slow_osc; // RQ14
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_rise = osc_sync_reg & ~osc_prev_reg;

    // One strobe per 8 oscillator rising edges
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            osc_cnt_reg     <= 3'h0;
            ticks.osc8_tick <= 1'b0;
        end
        else
        begin
            ticks.osc8_tick <= osc_rise && (osc_cnt_reg == ART_OSC_DIV_LAST); // RQ7
            if (osc_rise)
                osc_cnt_reg <= osc_cnt_reg + 3'h1;
        end
    end

endmodule

// ==== art_timer_properties.sv ====
// Port-level checker for the auto-reload timer top
`timescale 1ns/10ps
module art_timer_properties
    import art_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       slow_osc,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       irq_request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic run_reg;
    logic en_reg;

    // Shadows of run and enable, known only from writes
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            run_reg <= 1'b0;
        else if (sfr_wr && sfr_addr == ART_T1_CTRL_ADDR)
            run_reg <= sfr_wdata[ART_CTRL_RUN_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            en_reg <= 1'b0;
        else if (sfr_wr && sfr_addr == ART_IRQ_ENABLE_ADDR)
            en_reg <= sfr_wdata[ART_FLAG_T1_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    property p_rd_hold;
        !$past(sfr_rd) |-> $stable(sfr_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");

    property p_unmapped;
        sfr_rd && (sfr_addr < ART_T0_COUNT_LOW_ADDR
            || sfr_addr > ART_IRQ_ENABLE_ADDR) |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_t0_rw;
        sfr_wr && sfr_addr == ART_T0_COUNT_HIGH_ADDR ##1 !sfr_wr
        ##1 sfr_rd && !sfr_wr && sfr_addr == ART_T0_COUNT_HIGH_ADDR
        |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    a_t0_rw: assert property (p_t0_rw)
        else $error("first timer high byte lost its value");

    // Only valid with the run bit off, else the count moves
    property p_cnt_rw;
        !run_reg && sfr_wr && sfr_addr == ART_T1_COUNT_HIGH_ADDR
        ##1 !sfr_wr ##1 !run_reg && sfr_rd && !sfr_wr
            && sfr_addr == ART_T1_COUNT_HIGH_ADDR
        |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    a_cnt_rw: assert property (p_cnt_rw)
        else $error("stopped count changed");

    property p_ctrl_rw;
        sfr_wr && sfr_addr == ART_T1_CTRL_ADDR ##1 !sfr_wr
        ##1 sfr_rd && !sfr_wr && sfr_addr == ART_T1_CTRL_ADDR
        |=> sfr_rdata == ($past(sfr_wdata, 3) & ART_CTRL_MASK);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw)
        else $error("control readback wrong");

    property p_flag_bits;
        sfr_rd && sfr_addr == ART_IRQ_FLAG_ADDR
        |=> (sfr_rdata & ~ART_FLAG_MASK) == 8'h00;
    endproperty
    a_flag_bits: assert property (p_flag_bits)
        else $error("reserved flag bit set");

    property p_en_rw;
        sfr_wr && sfr_addr == ART_IRQ_ENABLE_ADDR ##1 !sfr_wr
        ##1 sfr_rd && !sfr_wr && sfr_addr == ART_IRQ_ENABLE_ADDR
        |=> sfr_rdata == ($past(sfr_wdata, 3) & ART_EN_MASK);
    endproperty
    a_en_rw: assert property (p_en_rw)
        else $error("enable readback wrong");

    property p_irq_gate;
        !en_reg && !$past(en_reg) |-> !irq_request;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt while disabled");
endmodule

bind art_timer_top art_timer_properties u_props
(
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .slow_osc    (slow_osc),
    .sfr_addr    (sfr_addr),
    .sfr_wr      (sfr_wr),
    .sfr_wdata   (sfr_wdata),
    .sfr_rd      (sfr_rd),
    .sfr_rdata   (sfr_rdata),
    .irq_request (irq_request)
);

// ==== auto_reload_timer_with_osc_capture_tb.sv ====
// Self-checking bench for the auto-reload timer pair
`timescale 1ns/10ps
module auto_reload_timer_with_osc_capture_tb
    import art_pkg::*;
;
    logic       clk_sys;
    logic       rst_n;
    logic       slow_osc = 1'b0;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic       irq_request;
    logic       osc_on;
    logic [7:0] rv;
    int         mismatches;
    int         checked;
    int         cyc = 0;

    art_timer_top uut
    (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .slow_osc    (slow_osc),
        .sfr_addr    (sfr_addr),
        .sfr_wr      (sfr_wr),
        .sfr_wdata   (sfr_wdata),
        .sfr_rd      (sfr_rd),
        .sfr_rdata   (sfr_rdata),
        .irq_request (irq_request)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Oscillator period of 8 clocks, so eight edges take 64 clocks
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (osc_on && cyc % 4 == 0)
            slow_osc <= ~slow_osc;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk_sys);
        sfr_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk_sys);
        sfr_rd   <= 1'b0;
        #1;
        v = sfr_rdata;
    endtask

    task automatic chk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        cmp(n, {8'h00, e}, {8'h00, v});
    endtask

    task automatic wirq(input int lim);
        for (int i = 0; i < lim && irq_request !== 1'b1; i++)
            @(posedge clk_sys) #1;
        if (irq_request !== 1'b1)
        begin
            $display("[ERR] irq wait exp 1 got %b", irq_request);
            mismatches++;
            stop_test();
        end
    endtask

    // Time between two interrupt rises, flags cleared in between
    task automatic gap(input int e);
        int s;
        wirq(300);
        s = cyc;
        wr(8'h59, 8'h00);
        @(posedge clk_sys) #1;
        wirq(300);
        cmp("irq gap", 16'(e), 16'(cyc - s));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        for (int a = 8'h52; a <= 8'h5a; a++)
            chk("reset", 8'(a), 8'h00);
        wr(8'h51, 8'hff);
        chk("unmapped", 8'h51, 8'h00);
    endtask

    task automatic s_regs();
        wr(8'h53, 8'h3c);
        chk("t0 high", 8'h53, 8'h3c);
        wr(8'h58, 8'h5a);
        chk("count high", 8'h58, 8'h5a);
        wr(8'h57, 8'hc3);
        chk("count low", 8'h57, 8'hc3);
        wr(8'h54, 8'hff);
        chk("ctrl", 8'h54, 8'h35);
        wr(8'h54, 8'h00);
        wr(8'h5a, 8'hff);
        chk("enable", 8'h5a, 8'h08);
    endtask

    task automatic s_ovf();
        wr(8'h56, 8'hff);
        wr(8'h55, 8'hfe);
        wr(8'h58, 8'hff);
        wr(8'h57, 8'hfe);
        wr(8'h54, 8'h04);
        gap(24);
        wr(8'h54, 8'h00);
        repeat (30) @(posedge clk_sys);
        chk("reloaded low", 8'h57, 8'hfe);
        chk("reloaded high", 8'h58, 8'hff);
        chk("ovf flags", 8'h59, 8'h18);
        wr(8'h59, 8'h00);
    endtask

    task automatic s_low();
        wr(8'h58, 8'h00);
        wr(8'h57, 8'hff);
        wr(8'h54, 8'h04);
        repeat (20) @(posedge clk_sys);
        wr(8'h54, 8'h00);
        #1;
        cmp("irq masked", 16'h0000, {15'h0, irq_request});
        chk("low flag", 8'h59, 8'h10);
        wr(8'h54, 8'h20);
        wirq(4);
        wr(8'h59, 8'h00);
    endtask

    task automatic s_cap();
        logic [7:0] v1;
        logic [7:0] v2;
        wr(8'h58, 8'hab);
        wr(8'h57, 8'hcd);
        wr(8'h54, 8'h10);
        osc_on <= 1'b1;
        gap(64);
        chk("cap low", 8'h55, 8'hcd);
        chk("cap high", 8'h56, 8'hab);
        chk("cap flag", 8'h59, 8'h08);
        // Running sys/12 count: 64 clocks between captures give 5 or 6
        wr(8'h54, 8'h14);
        wirq(300);
        wr(8'h59, 8'h00);
        @(posedge clk_sys) #1;
        wirq(300);
        rd(8'h55, v1);
        wr(8'h59, 8'h00);
        @(posedge clk_sys) #1;
        wirq(300);
        rd(8'h55, v2);
        v2 = v2 - v1;
        cmp("cap diff", 16'h0001,
            {15'h0, (v2 == 8'h05 || v2 == 8'h06)});
        wr(8'h54, 8'h00);
        wr(8'h59, 8'h00);
        repeat (80) @(posedge clk_sys);
        chk("cap off", 8'h59, 8'h00);
    endtask

    task automatic s_osc();
        wr(8'h56, 8'hff);
        wr(8'h55, 8'hfe);
        wr(8'h58, 8'hff);
        wr(8'h57, 8'hfe);
        wr(8'h54, 8'h05);
        gap(128);
        wr(8'h54, 8'h00);
    endtask

    initial
    begin
        rst_n      = 1'b0;
        sfr_addr   = 8'h00;
        sfr_wr     = 1'b0;
        sfr_wdata  = 8'h00;
        sfr_rd     = 1'b0;
        osc_on     = 1'b0;
        mismatches = 0;
        checked    = 0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        s_reset();
        s_regs();
        s_ovf();
        s_low();
        s_cap();
        s_osc();
        stop_test();
    end
endmodule
